// [verilog/pci_cfg_map.svh]
// Offsets, field positions, reset values and fixed codes of the PCI config block
`ifndef PCI_CFG_MAP_SVH
`define PCI_CFG_MAP_SVH

// Configuration dword offsets (byte address, low two bits ignored)
`define CFG_OFS_ID        8'h00
`define CFG_OFS_CMDSTAT   8'h04
`define CFG_OFS_CLASSREV  8'h08
`define CFG_OFS_LINE      8'h0c
`define CFG_OFS_IOBASE    8'h10
`define CFG_OFS_MEMBASE   8'h14
`define CFG_OFS_RAMBASE   8'h18
`define CFG_OFS_SUBSYS    8'h2c
`define CFG_OFS_ROMBASE   8'h30
`define CFG_OFS_CAPPTR    8'h34
`define CFG_OFS_INTR      8'h3c
`define CFG_OFS_PMCAP     8'h40
`define CFG_OFS_PMCSR     8'h44
// Operating-register alias offsets in the upper half
`define OP_OFS_DMA        8'hb8
`define OP_OFS_TEST       8'h98

// Command register fields
`define CMD_IO            0
`define CMD_MEM           1
`define CMD_MASTER        2
`define CMD_WRINV         4
`define CMD_PARITY        6
`define CMD_SERR          8
`define CMD_WMASK         16'h0157
// Status register fields
`define ST_DPR            8
`define ST_RTA            12
`define ST_RMA            13
`define ST_SSE            14
`define ST_DPE            15
`define ST_W1C_MASK       16'hf100
`define ST_DEVSEL         16'h0200
`define ST_CAPLIST        16'h0010
// Operating register fields
`define DMA_MODE_RDMULT   2
`define DMA_MODE_RDLINE   3
`define DMA_CTL_CACHE     7
`define CT5_BURSTX        2
`define CT3_WRINV         0

// Fixed values and writable masks
`define CLASS_CODE        24'h010000
`define HEADER_LAYOUT     8'h00
`define INT_PIN           8'h01
`define MIN_GRANT         8'h11
`define MAX_LATENCY       8'h40
`define IO_BASE_MASK      32'hffffff00
`define MEM_BASE_MASK     32'hfffffc00
`define RAM_BASE_MASK     32'hfffff000
`define ROM_BASE_MASK     32'hffff8001
`define CAP_PTR           8'h40
`define CAP_PM_ID         8'h01
`define PMC_VALUE         16'h0001
`define PMCSR_WMASK       16'h0003
`define RESET_ZERO32      32'h00000000

`endif

// [verilog/pci_cfg_pkg.sv]
// Types shared by the PCI configuration and read-command block
package pci_cfg_pkg;

  // PCI bus command codes
  typedef enum logic [3:0] {
    CMD_INTACK  = 4'b0000,
    CMD_SPECIAL = 4'b0001,
    CMD_IORD    = 4'b0010,
    CMD_IOWR    = 4'b0011,
    CMD_MEMRD   = 4'b0110,
    CMD_MEMWR   = 4'b0111,
    CMD_CFGRD   = 4'b1010,
    CMD_CFGWR   = 4'b1011,
    CMD_RDMULT  = 4'b1100,
    CMD_DUALAD  = 4'b1101,
    CMD_RDLINE  = 4'b1110,
    CMD_WRINV   = 4'b1111
  } pci_cmd_e;

  // Configuration access from the PCI target
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_s;

  // Transfer request from the DMA engine
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        fetch;
    logic [31:0] addr;
    logic [23:0] bytes;
  } dma_req_s;

  // Chosen master command
  typedef struct packed {
    logic     valid;
    logic     refused;
    pci_cmd_e code;
    logic [8:0] burst;
  } mst_cmd_s;

endpackage

// [verilog/pci_config_read_multiple.sv]
// PCI configuration header and master read-command selection
`timescale 1ns/1ps
`include "pci_cfg_map.svh"

module pci_config_read_multiple #(
  parameter bit          PM_VARIANT = 1'b1,     // Power-management variant
  parameter logic [15:0] MAKER_ID   = 16'h1234, // Arbitrary value
  parameter logic [15:0] PART_ID    = 16'h0042, // Arbitrary value
  parameter logic [7:0]  REV_CODE   = 8'h01,    // Arbitrary value
  parameter logic [15:0] BOARD_VID  = 16'h0000, // Arbitrary value
  parameter logic [15:0] BOARD_ID   = 16'h0000  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // Configuration cycles
  input  wire pci_cfg_pkg::cfg_req_s cfgReq,
  output logic [31:0]                cfgRdData,
  output logic                       cfgAck,
  // Master transfer request and chosen command
  input  wire pci_cfg_pkg::dma_req_s dmaReq,
  output pci_cfg_pkg::mst_cmd_s      mstCmd,
  // Target decode
  input  wire logic                  tgtValid,
  input  wire logic [3:0]            tgtCmd,
  input  wire logic                  tgtIoHit,
  input  wire logic                  tgtMemHit,
  output logic                       tgtClaim,
  // Bus events
  input  wire logic                  dataParErr,
  input  wire logic                  addrParErr,
  input  wire logic                  perrAsMaster,
  input  wire logic                  masterAbort,
  input  wire logic                  targetAbort,
  output logic                       serrAssert,
  // Enables for the bus engine
  output logic                       busMasterEn,
  output logic                       memWrInvEn
);
  import pci_cfg_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0] command_r;   // Command register
  logic [15:0] status_r;    // Sticky status bits
  logic [7:0]  clsLen_r;    // Cache line length in dwords
  logic [7:0]  tenure_r;    // Bus tenure timer
  logic [31:0] ioBase_r;    // I/O window base
  logic [31:0] memBase_r;   // Memory window base
  logic [31:0] ramBase_r;   // On-chip RAM base
  logic [31:0] romBase_r;   // Option ROM base
  logic [7:0]  intRoute_r;  // Interrupt routing
  logic [15:0] pmCsr_r;     // Power control/state
  logic [7:0]  dmaMode_r;   // DMA mode register
  logic [7:0]  dmaCtl_r;    // DMA control register
  logic [7:0]  burstExt_r;  // Burst extension control
  logic [7:0]  wrInvAux_r;  // Write-invalidate auxiliary control

  //////////////////////////////////////////////////////////////////////////////
  // Write decode

  // Merge written bytes into an old value
  function automatic logic [31:0] mergeBe(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  logic        cfgWr;       // Config write this cycle
  logic [5:0]  dw;          // Dword index addressed
  logic [31:0] wdMerged;    // Written data with unwritten bytes zero
  logic        pmSpace;     // Capability dwords present

  assign cfgWr    = cfgReq.sel && cfgReq.write;
  assign dw       = cfgReq.addr[7:2];
  assign wdMerged = mergeBe(`RESET_ZERO32, cfgReq.wdata, cfgReq.be);
  assign pmSpace  = PM_VARIANT;

  // Address compare against a map offset
  function automatic logic hit(input logic [5:0] idx, input logic [7:0] ofs);
    return idx == ofs[7:2];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Command register

  // Only implemented bits take written values
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      command_r <= 16'h0000;
    end else if (cfgWr && hit(dw, `CFG_OFS_CMDSTAT)) begin
      command_r <= {(cfgReq.be[1] ? cfgReq.wdata[15:8] : command_r[15:8]),
                    (cfgReq.be[0] ? cfgReq.wdata[7:0] : command_r[7:0])} & `CMD_WMASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status register

  logic [15:0] stSet;  // Events this cycle
  logic [15:0] stClr;  // Bits written with one
  logic        serrNow;

  // Address parity reported only with both enables
  assign serrNow = addrParErr && command_r[`CMD_SERR] && command_r[`CMD_PARITY];

  always_comb begin
    stSet = 16'h0000;
    stSet[`ST_DPE] = dataParErr;
    stSet[`ST_SSE] = serrNow;
    stSet[`ST_RMA] = masterAbort;
    stSet[`ST_RTA] = targetAbort;
    stSet[`ST_DPR] = dataParErr && perrAsMaster && command_r[`CMD_PARITY];
  end

  // Clear applies to high half of the command/status dword
  assign stClr = (cfgWr && hit(dw, `CFG_OFS_CMDSTAT)) ?
                 (wdMerged[31:16] & `ST_W1C_MASK) : 16'h0000;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_r <= 16'h0000;
    end else begin
      status_r <= (status_r & ~stClr) | stSet;
    end
  end

  // System error driven one cycle after the fault
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      serrAssert <= 1'b0;
    end else begin
      serrAssert <= serrNow;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Header read/write registers

  // Line length, timer, window bases, routing, power state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clsLen_r   <= 8'h00;
      tenure_r   <= 8'h00;
      ioBase_r   <= `RESET_ZERO32;
      memBase_r  <= `RESET_ZERO32;
      ramBase_r  <= `RESET_ZERO32;
      romBase_r  <= `RESET_ZERO32;
      intRoute_r <= 8'h00;
      pmCsr_r    <= 16'h0000;
    end else if (cfgWr) begin
      if (hit(dw, `CFG_OFS_LINE)) begin
        if (cfgReq.be[0]) begin
          clsLen_r <= cfgReq.wdata[7:0];
        end
        if (cfgReq.be[1]) begin
          tenure_r <= cfgReq.wdata[15:8];
        end
      end
      if (hit(dw, `CFG_OFS_IOBASE)) begin
        ioBase_r <= mergeBe(ioBase_r, cfgReq.wdata, cfgReq.be) & `IO_BASE_MASK;
      end
      if (hit(dw, `CFG_OFS_MEMBASE)) begin
        memBase_r <= mergeBe(memBase_r, cfgReq.wdata, cfgReq.be) & `MEM_BASE_MASK;
      end
      if (hit(dw, `CFG_OFS_RAMBASE)) begin
        ramBase_r <= mergeBe(ramBase_r, cfgReq.wdata, cfgReq.be) & `RAM_BASE_MASK;
      end
      if (hit(dw, `CFG_OFS_ROMBASE)) begin
        romBase_r <= mergeBe(romBase_r, cfgReq.wdata, cfgReq.be) & `ROM_BASE_MASK;
      end
      if (hit(dw, `CFG_OFS_INTR) && cfgReq.be[0]) begin
        intRoute_r <= cfgReq.wdata[7:0];
      end
      // Power state exists only on the power variant
      if (pmSpace && hit(dw, `CFG_OFS_PMCSR)) begin
        pmCsr_r <= {(cfgReq.be[1] ? cfgReq.wdata[15:8] : pmCsr_r[15:8]),
                    (cfgReq.be[0] ? cfgReq.wdata[7:0] : pmCsr_r[7:0])} & `PMCSR_WMASK;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operating registers aliased in the upper half

  // Upper 128 bytes reach the DMA control registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dmaMode_r  <= 8'h00;
      dmaCtl_r   <= 8'h00;
      burstExt_r <= 8'h00;
      wrInvAux_r <= 8'h00;
    end else if (cfgWr && cfgReq.addr[7]) begin
      if (hit(dw, `OP_OFS_DMA)) begin
        if (cfgReq.be[0]) begin
          dmaMode_r <= cfgReq.wdata[7:0];
        end
        if (cfgReq.be[3]) begin
          dmaCtl_r <= cfgReq.wdata[31:24];
        end
      end
      if (hit(dw, `OP_OFS_TEST)) begin
        if (cfgReq.be[0]) begin
          wrInvAux_r <= cfgReq.wdata[7:0];
        end
        if (cfgReq.be[3]) begin
          burstExt_r <= cfgReq.wdata[31:24];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration read

  logic [31:0] rdMux;

  // Everything not listed reads as zero
  always_comb begin
    rdMux = `RESET_ZERO32;
    if (cfgReq.addr[7]) begin
      if (hit(dw, `OP_OFS_DMA)) begin
        rdMux = {dmaCtl_r, 16'h0000, dmaMode_r};
      end else if (hit(dw, `OP_OFS_TEST)) begin
        rdMux = {burstExt_r, 16'h0000, wrInvAux_r};
      end
    end else begin
      case (dw)
        `CFG_OFS_ID >> 2:       rdMux = {PART_ID, MAKER_ID};
        `CFG_OFS_CMDSTAT >> 2:  rdMux = {status_r | `ST_DEVSEL |
                                         (pmSpace ? `ST_CAPLIST : 16'h0000),
                                         command_r};
        `CFG_OFS_CLASSREV >> 2: rdMux = {`CLASS_CODE, REV_CODE};
        `CFG_OFS_LINE >> 2:     rdMux = {8'h00, `HEADER_LAYOUT, tenure_r, clsLen_r};
        `CFG_OFS_IOBASE >> 2:   rdMux = ioBase_r | 32'h00000001;
        `CFG_OFS_MEMBASE >> 2:  rdMux = memBase_r;
        `CFG_OFS_RAMBASE >> 2:  rdMux = ramBase_r;
        `CFG_OFS_SUBSYS >> 2:   rdMux = {BOARD_ID, BOARD_VID};
        `CFG_OFS_ROMBASE >> 2:  rdMux = romBase_r;
        `CFG_OFS_CAPPTR >> 2:   rdMux = {24'h000000, pmSpace ? `CAP_PTR : 8'h00};
        `CFG_OFS_INTR >> 2:     rdMux = {`MAX_LATENCY, `MIN_GRANT, `INT_PIN, intRoute_r};
        `CFG_OFS_PMCAP >> 2:    rdMux = pmSpace ? {`PMC_VALUE, 8'h00, `CAP_PM_ID}
                                                : `RESET_ZERO32;
        `CFG_OFS_PMCSR >> 2:    rdMux = pmSpace ? {16'h0000, pmCsr_r}
                                                : `RESET_ZERO32;
        default:                rdMux = `RESET_ZERO32;
      endcase
    end
  end

  // Read data and acknowledge one cycle after the access
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfgRdData <= `RESET_ZERO32;
      cfgAck    <= 1'b0;
    end else begin
      cfgAck <= cfgReq.sel;
      if (cfgReq.sel && !cfgReq.write) begin
        cfgRdData <= rdMux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Target claim

  // Only supported commands with their space enabled are claimed
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tgtClaim <= 1'b0;
    end else begin
      tgtClaim <= 1'b0;
      if (tgtValid) begin
        case (tgtCmd)
          CMD_IORD, CMD_IOWR:
            tgtClaim <= tgtIoHit && command_r[`CMD_IO];
          CMD_MEMRD, CMD_MEMWR, CMD_RDMULT, CMD_RDLINE, CMD_WRINV:
            tgtClaim <= tgtMemHit && command_r[`CMD_MEM];
          default:
            tgtClaim <= 1'b0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Master command choice

  logic        cacheOn;   // Cache mode enabled
  logic [2:0]  burstCode; // Burst size selection
  logic [8:0]  burstMax;  // Burst cap in dwords
  logic        clsLegal;  // Line size is a legal burst
  logic        clsFits;   // Line size within burst cap
  logic        aligned;   // Address on a line boundary
  logic [7:0]  clsMask;   // Line size minus one
  logic [21:0] dwLeft;    // Remaining dwords
  logic [8:0]  nDw;       // Remaining dwords under cap
  logic        rmOk;      // Read multiple conditions
  logic        rlOk;      // Read line conditions
  logic        wiOk;      // Write invalidate conditions
  logic        wiEnable;  // Write invalidate permitted

  assign cacheOn   = dmaCtl_r[`DMA_CTL_CACHE];
  assign burstCode = {dmaMode_r[7:6], burstExt_r[`CT5_BURSTX]};
  assign burstMax  = 9'h002 << burstCode;
  assign clsMask   = clsLen_r - 8'h01;
  assign clsLegal  = !clsLen_r[0] && (clsLen_r != 8'h00) &&
                     ((clsLen_r & clsMask) == 8'h00);
  assign clsFits   = {1'b0, clsLen_r} <= burstMax;
  assign aligned   = (dmaReq.addr[1:0] == 2'b00) &&
                     ((dmaReq.addr[9:2] & clsMask) == 8'h00);
  assign dwLeft    = dmaReq.bytes[23:2];
  assign nDw       = (dwLeft > {13'h0000, burstMax}) ? burstMax : dwLeft[8:0];
  assign wiEnable  = command_r[`CMD_WRINV] && wrInvAux_r[`CT3_WRINV];

  assign rmOk = dmaMode_r[`DMA_MODE_RDMULT] && cacheOn && clsLegal && clsFits &&
                aligned && !dmaReq.fetch && !dmaReq.write &&
                (dmaReq.bytes >= {13'h0000, clsLen_r, 3'h0});
  assign rlOk = dmaMode_r[`DMA_MODE_RDLINE] && !dmaReq.fetch && !dmaReq.write &&
                (!cacheOn || (clsLegal && clsFits && aligned &&
                 dmaReq.bytes >= {13'h0000, burstMax, 2'h0}));
  assign wiOk = wiEnable && cacheOn && clsLegal && clsFits && aligned &&
                dmaReq.write && (dmaReq.bytes >= {14'h0000, clsLen_r, 2'h0});

  // Command and burst chosen one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mstCmd <= '{valid: 1'b0, refused: 1'b0, code: CMD_MEMRD, burst: 9'h000};
    end else begin
      mstCmd.valid   <= 1'b0;
      mstCmd.refused <= 1'b0;
      if (dmaReq.valid) begin
        if (!command_r[`CMD_MASTER]) begin
          mstCmd.refused <= 1'b1;
        end else begin
          mstCmd.valid <= 1'b1;
          mstCmd.burst <= (nDw == 9'h000) ? 9'h001 : nDw;
          if (rmOk) begin
            mstCmd.code  <= CMD_RDMULT;
            mstCmd.burst <= nDw & ~{1'b0, clsMask};
          end else if (rlOk) begin
            mstCmd.code <= CMD_RDLINE;
          end else if (wiOk) begin
            mstCmd.code  <= CMD_WRINV;
            mstCmd.burst <= nDw & ~{1'b0, clsMask};
          end else if (dmaReq.write) begin
            mstCmd.code <= CMD_MEMWR;
          end else begin
            mstCmd.code <= CMD_MEMRD;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Enable outputs

  // Registered copies for the bus engine
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busMasterEn <= 1'b0;
      memWrInvEn  <= 1'b0;
    end else begin
      busMasterEn <= command_r[`CMD_MASTER];
      memWrInvEn  <= wiEnable;
    end
  end

endmodule // pci_config_read_multiple

// [tb/pci_cfg_rm_chk.sv]
// Port assertions for the PCI config and read-command block
`timescale 1ns/1ps
module pci_cfg_rm_chk (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  reset,
  // Config and master sides
  input wire pci_cfg_pkg::cfg_req_s cfgReq,
  input wire logic                  cfgAck,
  input wire pci_cfg_pkg::dma_req_s dmaReq,
  input wire pci_cfg_pkg::mst_cmd_s mstCmd,
  input wire logic                  busMasterEn,
  // Target and events
  input wire logic                  tgtValid,
  input wire logic [3:0]            tgtCmd,
  input wire logic                  tgtClaim,
  input wire logic                  addrParErr,
  input wire logic                  serrAssert
);
  import pci_cfg_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  // Steps of an access
  sequence s_cfg;
    cfgReq.sel;
  endsequence
  sequence s_mreq;
    dmaReq.valid;
  endsequence
  ////////////////////////////////////////////////////////////
  property p_ack;
    s_cfg |=> cfgAck;
  endproperty
  a_ack: assert property (p_ack) else $error("config access unanswered");
  property p_ack_src;
    cfgAck |-> $past(cfgReq.sel);
  endproperty
  a_ack_src: assert property (p_ack_src) else $error("stray config ack");
  // Enable copy lags the command bit, so it matches the decision at the answer edge
  property p_refuse;
    s_mreq |=> busMasterEn || (mstCmd.refused && !mstCmd.valid);
  endproperty
  a_refuse: assert property (p_refuse) else $error("master request not refused");
  property p_grant;
    s_mreq |=> !busMasterEn || (mstCmd.valid && !mstCmd.refused);
  endproperty
  a_grant: assert property (p_grant) else $error("master request lost");
  property p_fetch;
    s_mreq ##0 (dmaReq.fetch || dmaReq.write) |=> mstCmd.code != CMD_RDMULT;
  endproperty
  a_fetch: assert property (p_fetch) else $error("read multiple on fetch or write");
  property p_legal;
    mstCmd.valid |-> !(mstCmd.code inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hd});
  endproperty
  a_legal: assert property (p_legal) else $error("unsupported command issued");
  property p_noclaim;
    tgtValid && (tgtCmd inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hd}) |=> !tgtClaim;
  endproperty
  a_noclaim: assert property (p_noclaim) else $error("unsupported command claimed");
  property p_claim_src;
    tgtClaim |-> $past(tgtValid);
  endproperty
  a_claim_src: assert property (p_claim_src) else $error("claim without a cycle");
  property p_burst;
    mstCmd.valid && mstCmd.code == CMD_RDMULT |-> !mstCmd.burst[0] && mstCmd.burst >= 9'h002;
  endproperty
  a_burst: assert property (p_burst) else $error("read multiple burst not line sized");
  property p_serr;
    serrAssert |-> $past(addrParErr);
  endproperty
  a_serr: assert property (p_serr) else $error("system error without cause");
endmodule // pci_cfg_rm_chk

// [tb/pci_host_model.sv]
// Behavioural PCI host that issues configuration cycles
`timescale 1ns/1ps
module pci_host_model (
  // Clock
  input  wire logic                  clk_sys,
  // Config cycle to the device
  output pci_cfg_pkg::cfg_req_s      cfgReq,
  input  wire logic                  cfgAck,
  input  wire logic [31:0]           cfgRdData
);
  import pci_cfg_pkg::*;
  initial cfgReq = '0;
  // One access: select for one cycle, then a bounded wait for the answer
  task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] q, output bit ok);
    int k;
    @(negedge clk_sys);
    cfgReq = '{1'b1, w, a, be, d};
    ok = 0;
    for (k = 0; k < 4 && !ok; k++) begin
      @(negedge clk_sys);
      // Released lines show the inverse, so nothing stale can match
      cfgReq = '{1'b0, ~w, ~a, ~be, ~d};
      ok = (cfgAck === 1'b1);
    end
    q = cfgRdData;
    @(negedge clk_sys);
  endtask
endmodule // pci_host_model

// [tb/test_pci_config_read_multiple.sv]
// Self-checking bench for the PCI config and read-command block
`timescale 1ns/1ps
module test_pci_config_read_multiple;
  import pci_cfg_pkg::*;
  logic        clk_sys, reset;            // Clock and reset
  cfg_req_s    cfgReq;                    // From the host model
  logic [31:0] cfgRdData, q;              // Read data, last read
  logic        cfgAck, tgtValid, tgtIoHit, tgtMemHit, tgtClaim;
  dma_req_s    dmaReq;                    // Master request
  mst_cmd_s    mstCmd;                    // Chosen command
  logic [3:0]  tgtCmd;                    // Target bus command
  logic        dataParErr, addrParErr, perrAsMaster, masterAbort, targetAbort;
  logic        serrAssert, busMasterEn, memWrInvEn;
  bit          ok;                        // Host answered in time
  int          error_cnt, n_compared, i, r;
  int          seed = 93212;
  int          lines[9] = '{2, 4, 8, 16, 32, 64, 128, 3, 0};
  ////////////////////////////////////////////////////////////
  pci_host_model host (.clk_sys(clk_sys), .cfgReq(cfgReq), .cfgAck(cfgAck), .cfgRdData(cfgRdData));
  pci_config_read_multiple dut (.clk_sys(clk_sys), .reset(reset), .cfgReq(cfgReq),
    .cfgRdData(cfgRdData), .cfgAck(cfgAck), .dmaReq(dmaReq), .mstCmd(mstCmd),
    .tgtValid(tgtValid), .tgtCmd(tgtCmd), .tgtIoHit(tgtIoHit), .tgtMemHit(tgtMemHit),
    .tgtClaim(tgtClaim), .dataParErr(dataParErr), .addrParErr(addrParErr),
    .perrAsMaster(perrAsMaster), .masterAbort(masterAbort), .targetAbort(targetAbort),
    .serrAssert(serrAssert), .busMasterEn(busMasterEn), .memWrInvEn(memWrInvEn));
  // Clock generator
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////
  // Report and end
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Compare one value
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Config access through the host, timeout ends the run
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    host.access(w, a, be, d, q, ok);
    if (!ok) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    xfer(1'b1, a, be, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 4'hf, 32'h0);
    cmp(q, e);
  endtask
  // One master request pulse
  task automatic mreq(input logic f, input logic [31:0] a, input logic [23:0] n);
    @(negedge clk_sys) dmaReq = '{1'b1, 1'b0, f, a, n};
    @(negedge clk_sys) dmaReq.valid = 1'b0;
  endtask
  // One target decode strobe and its claim
  task automatic tgt(input logic [3:0] c, input logic io, mem, e);
    @(negedge clk_sys) {tgtValid, tgtCmd, tgtIoHit, tgtMemHit} = {1'b1, c, io, mem};
    @(negedge clk_sys) tgtValid = 1'b0;
    cmp(tgtClaim, e);
  endtask
  // Burst expected for read multiple, zero when a plain read is due
  function automatic int exp_burst(int ln, cap, bit cm, rm, int a, n, bit f);
    int d;
    d = (n / 4 < cap) ? n / 4 : cap;
    if (!cm || !rm || f || !(ln inside {2, 4, 8, 16, 32, 64, 128}) || ln > cap || n < 8 * ln
        || a % (4 * ln) != 0)
      return 0;
    return d / ln * ln;
  endfunction
  // Program line size and modes, then request a read
  task automatic trial(input bit cm, rm, rl, input bit [2:0] cb, input int ln, input bit f, input int a, n);
    int e;
    e = exp_burst(ln, 2 << cb, cm, rm, a, n, f);
    wr(8'h0c, 4'hf, ln);
    wr(8'hb8, 4'hf, {cm, 23'h0, cb[2:1], 2'b0, rl, rm, 2'b0});
    wr(8'h98, 4'hf, {5'h0, cb[0], 26'h0});
    mreq(f, a, 24'(n));
    cmp(mstCmd.valid, 1'b1);
    cmp(mstCmd.code, e ? CMD_RDMULT : CMD_MEMRD);
    if (e != 0)
      cmp(mstCmd.burst, e);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1;
    dmaReq = '0;
    {tgtValid, tgtCmd, tgtIoHit, tgtMemHit} = '0;
    {dataParErr, addrParErr, perrAsMaster, masterAbort, targetAbort} = '0;
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    rd(8'h04, 32'h02100000);
    rd(8'h1c, 32'h0);
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(8'h48 + 8'(4 * r[3:0] % 56), 4'hf, 32'hffffffff);
      rd(8'h48 + 8'(4 * r[3:0] % 56), 32'h0);
    end
    mreq(1'b0, 32'h1000, 24'h400);
    cmp(mstCmd.refused, 1'b1);
    tgt(4'h6, 1'b1, 1'b1, 1'b0);
    wr(8'h04, 4'h3, 32'hffffffff);
    rd(8'h04, 32'h02100157);
    cmp(memWrInvEn, 1'b0);
    wr(8'h98, 4'hf, 32'h1);
    cmp(memWrInvEn, 1'b1);
    for (i = 0; i < 16; i++)
      if (i != 10 && i != 11)
        tgt(4'(i), 1'b1, 1'b1, i inside {2, 3, 6, 7, 12, 14, 15});
    wr(8'h04, 4'h3, 32'h0146);
    tgt(4'h2, 1'b1, 1'b0, 1'b0);
    tgt(4'h7, 1'b0, 1'b1, 1'b1);
    wr(8'h04, 4'h3, 32'h0007);
    @(negedge clk_sys) {dataParErr, masterAbort} = 2'b11;
    @(negedge clk_sys) {dataParErr, masterAbort} = 2'b00;
    rd(8'h04, 32'ha2100007);
    wr(8'h04, 4'hc, 32'h80000000);
    rd(8'h04, 32'h22100007);
    wr(8'h04, 4'hc, 32'h20000000);
    rd(8'h04, 32'h02100007);
    wr(8'h04, 4'h3, 32'h0047);
    @(negedge clk_sys) addrParErr = 1'b1;
    @(negedge clk_sys) addrParErr = 1'b0;
    cmp(serrAssert, 1'b0);
    wr(8'h04, 4'h3, 32'h0147);
    @(negedge clk_sys) addrParErr = 1'b1;
    @(negedge clk_sys) addrParErr = 1'b0;
    cmp(serrAssert, 1'b1);
    rd(8'h04, 32'h42100147);
    @(negedge clk_sys) {dataParErr, perrAsMaster, targetAbort} = 3'b111;
    @(negedge clk_sys) {dataParErr, perrAsMaster, targetAbort} = 3'b000;
    rd(8'h04, 32'hd3100147);
    wr(8'h04, 4'hc, 32'hf1000000);
    rd(8'h04, 32'h02100147);
    trial(1, 1, 0, 7, 8, 0, 'h1000, 64);
    trial(1, 1, 0, 7, 8, 0, 'h1000, 60);
    trial(1, 1, 1, 7, 8, 0, 'h1000, 'h400);
    trial(1, 0, 0, 7, 8, 0, 'h1000, 'h400);
    trial(0, 1, 0, 7, 8, 0, 'h1000, 'h400);
    trial(1, 1, 0, 7, 3, 0, 'h1000, 'h400);
    trial(1, 1, 0, 2, 16, 0, 'h1000, 'h400);
    trial(1, 1, 0, 7, 8, 1, 'h1000, 'h400);
    trial(1, 1, 0, 7, 8, 0, 'h1004, 'h400);
    trial(1, 1, 0, 0, 2, 0, 'h1000, 'h1000);
    mreq(1'b0, 32'h1000, 24'h400);
    mreq(1'b1, 32'h1000, 24'h400);
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      trial(r[0] | r[1], r[2] | r[3], 0, r[12:10], lines[r[9:6] % 9], r[4] & r[5],
            'h1000 + 4 * lines[r[9:6] % 9] * r[17:14] + 4 * r[13], r[29:18] + 8 * lines[r[9:6] % 9]);
    end
    give_verdict();
  end
endmodule // test_pci_config_read_multiple

bind pci_config_read_multiple pci_cfg_rm_chk chk (.clk_sys(clk_sys), .reset(reset), .cfgReq(cfgReq),
  .cfgAck(cfgAck), .dmaReq(dmaReq), .mstCmd(mstCmd), .busMasterEn(busMasterEn), .tgtValid(tgtValid),
  .tgtCmd(tgtCmd), .tgtClaim(tgtClaim), .addrParErr(addrParErr), .serrAssert(serrAssert));
